// file: dv/mmsc_asserts.sv
// Link checker: wire resolution, device clock timing, quiet reset of device drivers and peer line a
module mmsc_asserts (
    // Clock and reset
    input wire logic clk, rst_b,
    // Drivers of both ends
    input wire logic dev_sck_o, dev_sck_oe, dev_a_o, dev_a_oe, dev_b_o, dev_b_oe,
    input wire logic peer_sck_o, peer_sck_oe, peer_a_o, peer_a_oe, peer_b_o, peer_b_oe,
    // Resolved wires
    input wire logic sck, line_a, line_b
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sck_wire_a: assert property (sck == !((dev_sck_oe && !dev_sck_o) || (peer_sck_oe && !peer_sck_o)))
        else $error("sck level wrong");
    line_a_wire_a: assert property (line_a == !((dev_a_oe && !dev_a_o) || (peer_a_oe && !peer_a_o)))
        else $error("line a level wrong");
    line_b_wire_a: assert property (line_b == !((dev_b_oe && !dev_b_o) || (peer_b_oe && !peer_b_o)))
        else $error("line b level wrong");
    reset_quiet_a: assert property ($rose(rst_b) |-> !(dev_sck_oe || dev_a_oe || dev_b_oe || peer_a_oe))
        else $error("driver on after reset");
    clock_low_a: assert property ($fell(dev_sck_o) && dev_sck_oe |-> !dev_sck_o [*4])
        else $error("clock low too short");
    clock_high_a: assert property ($rose(dev_sck_o) && dev_sck_oe |-> dev_sck_o [*4])
        else $error("clock high too short");
    one_master_a: assert property (!(dev_sck_oe && peer_sck_oe))
        else $error("two clock drivers");
    rise_data_a: assert property ($rose(dev_sck_o) && dev_sck_oe && $stable(dev_sck_oe)
        |-> $stable(dev_a_o) && $stable(dev_b_o))
        else $error("data moved on rise");
    cover property ($fell(line_a) && sck);
    cover property ($rose(dev_sck_o) && dev_sck_oe);
    cover property ($fell(dev_b_o) && dev_b_oe);
endmodule // mmsc_asserts

// file: dv/mmsc_tb.sv
// Bench: device and peer joined over the link, driven through APB
module mmsc_tb import mmsc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, tx_start = 0, sc = 0;
    logic [7:0] paddr = 0, txd = 8'hff, rxd, a, b;
    logic [31:0] pwdata = 0, prdata, rd, seed = 46;
    logic pready, pslverr, irq, busy, err, rxv, clsb = 0, cline = 0, cmst = 0;
    mmsc_mode_e cmode = MMSC_STOP;
    int n_fail = 0, check_count = 0, cyc = 0, nrx = 0;
    mmsc_if lnk();
    mmsc_dev mmsc_dev_i (.clk(clk), .rst_b(rst_b), .ce(1'b1), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .transfer_interrupt(irq), .lnk(lnk));
    mmsc_peer mmsc_peer_i (.clk(clk), .rst_b(rst_b), .ce(1'b1), .cfg_mode(cmode), .cfg_lsb(clsb),
        .cfg_line_b(cline), .cfg_master(cmst), .tx_data(txd), .tx_start(tx_start), .tx_start_cond(sc),
        .tx_stop_cond(1'b0), .busy(busy), .rx_data(rxd), .rx_valid(rxv), .lnk(lnk));
    mmsc_asserts mmsc_asserts_i (.clk(clk), .rst_b(rst_b), .dev_sck_o(lnk.dev_sck_o), .dev_sck_oe(lnk.dev_sck_oe),
        .dev_a_o(lnk.dev_a_o), .dev_a_oe(lnk.dev_a_oe), .dev_b_o(lnk.dev_b_o), .dev_b_oe(lnk.dev_b_oe),
        .peer_sck_o(lnk.peer_sck_o), .peer_sck_oe(lnk.peer_sck_oe), .peer_a_o(lnk.peer_a_o),
        .peer_a_oe(lnk.peer_a_oe), .peer_b_o(lnk.peer_b_o), .peer_b_oe(lnk.peer_b_oe), .sck(lnk.sck),
        .line_a(lnk.line_a), .line_b(lnk.line_b));
    initial forever #50 clk = ~clk;
    // Every finished peer word pulses once
    always @(posedge clk) begin
        if (rxv === 1'b1)
            nrx <= nrx + 1;
    end
    // Hang guard, far above the longest sequence
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_fail++;
            give_verdict();
        end
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] rev(input logic [7:0] v);
        for (int i = 0; i < 8; i++) rev[i] = v[7-i];
    endfunction
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", s, e, g);
            n_fail++;
        end
    endtask
    // Master waits for pready with no assumed latency
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk);
        psel <= 1; penable <= 0; paddr <= ad; pwrite <= w; pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic rdc(input logic [7:0] ad, input logic [31:0] e, input string s);
        apb(0, ad, 0);
        chk(s, e, rd);
    endtask
    task automatic wirq(input int n, input logic e, input string s);
        for (int k = 0; k < n && irq !== 1'b1; k++) @(posedge clk);
        chk(s, e, irq);
    endtask
    // Extra edge so busy is already up before the wait; returns once busy drops
    task automatic pstart(input logic [7:0] d, input logic s);
        @(posedge clk); txd <= d; sc <= s; tx_start <= 1;
        @(posedge clk); tx_start <= 0;
        @(posedge clk);
        while (busy !== 1'b0) @(posedge clk);
    endtask
    task automatic pload(input logic [7:0] d);
        @(posedge clk); txd <= d; sc <= 0; tx_start <= 1;
        @(posedge clk); tx_start <= 0;
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1;
        rdc(8'h04, 0, "mode rst");
        rdc(8'h10, 0, "sva rst");
        apb(0, 8'h14, 0); chk("slverr", 1, err);
        apb(1, 8'h00, 32'h5a); wirq(150, 0, "stopped");
        cmode <= MMSC_3W;
        for (int i = 0; i < 6; i++) begin
            a = (i < 2) ? 8'h80 >> (7 * i) : 8'(rnd());
            b = (i < 2) ? 8'hff >> (7 * i) : 8'(rnd());
            apb(1, 8'h04, 32'h81 + 32'(4 * (i % 2)));
            clsb <= (i == 3);
            pload(b);
            apb(1, 8'h00, {24'h0, a}); wirq(400, 1, "3w end");
            while (busy !== 1'b0) @(posedge clk);
            chk("peer rx", (i % 4 == 1) ? rev(a) : a, rxd);
            rdc(8'h00, (i % 4 == 1) ? rev(b) : b, "dev rx");
            apb(1, 8'h0c, 1); @(posedge clk); chk("irq clear", 0, irq);
            apb(1, 8'h04, 0);
        end
        apb(1, 8'h04, 32'h81); apb(1, 8'h04, 32'h82); rdc(8'h04, 32'h81, "mode lock");
        apb(1, 8'h04, 0);
        cmode <= MMSC_2W;
        for (int i = 0; i < 2; i++) begin
            a = 8'(rnd()); cline <= 1'(i);
            apb(1, 8'h04, 32'h82 + 32'(8 * i)); pload(8'hff);
            apb(1, 8'h00, {24'h0, a}); wirq(400, 1, "2w end");
            while (busy !== 1'b0) @(posedge clk);
            chk("2w rx", a, rxd);
            rdc(8'h00, a, "2w echo");
            apb(1, 8'h0c, 1);
            apb(1, 8'h08, 32'h12); repeat (2) @(posedge clk);
            chk("sck low", 0, lnk.sck); chk("data low", 0, i ? lnk.line_b : lnk.line_a);
            apb(1, 8'h08, 32'h11); apb(1, 8'h08, 0); repeat (2) @(posedge clk);
            chk("sck high", 1, lnk.sck); chk("data high", 1, i ? lnk.line_b : lnk.line_a);
            apb(1, 8'h04, 0);
        end
        cmode <= MMSC_I2C; cline <= 0;
        apb(1, 8'h04, 32'h83); apb(1, 8'h08, 32'h80); apb(1, 8'h00, 32'hff);
        wirq(400, 1, "i2c preload");
        apb(1, 8'h0c, 32'h0d); apb(1, 8'h04, 0);
        a = 8'h5c; apb(1, 8'h10, {24'h0, a});
        apb(1, 8'h04, 32'ha3); cmst <= 1;
        pstart(a ^ 8'h01, 1); chk("no wake", 0, irq);
        pstart(a, 1); wirq(50, 1, "wake");
        apb(0, 8'h0c, 0); chk("wake st", 32'h45, rd & 32'h45);
        apb(1, 8'h00, 32'h33); rdc(8'h00, a, "wake hold");
        chk("rx words", 10, nrx);
        give_verdict();
    end
endmodule // mmsc_tb

// file: rtl/mmsc_defines.svh
// Constants for the multi-mode serial channel
// What this block does
// R01: Stopped, three-wire, two-wire and I2C modes
// R02: Software changes mode only while disabled; a write that clears enable also changes it
// R03: Stopped mode keeps shifter and clock idle
// R04: Three-wire: 8-bit full-duplex over three lines
// R05: Three-wire bit order MSB or LSB first
// R06: Two-wire: MSB first, one selectable data line
// R07: Two-wire: software forces clock and data levels
// R08: I2C: MSB first with start, data, stop
// R09: I2C receive detects start, data, stop
// R10: 8-bit shift register, whole-byte writes only
// R11: Data write starts transfer only when enabled
// R12: Shift out latch, shift in selected line
// R13: Receiver preloads all ones to release line
// R14: I2C all-ones preload only with busy enable; the busy bit is not checked
// R15: Shift register not reset, unknown after reset
// R16: No data writes in wakeup; receive continues
// R17: Flag after every eight counted serial clocks, except in wakeup
// R18: Two-wire shifts on fall, captures on rise
// R19: Wakeup flags address match or stop only
// R20: Starting write clears serial clock counter
`ifndef MMSC_DEFINES_SVH
`define MMSC_DEFINES_SVH
`define MMSC_OFF_DATA     8'h00
`define MMSC_OFF_MODE     8'h04
`define MMSC_OFF_BUSCTL   8'h08
`define MMSC_OFF_STATUS   8'h0c
`define MMSC_OFF_SVA      8'h10
`define MMSC_MODE_EN      7
`define MMSC_MODE_WAKE    5
`define MMSC_MODE_LINEB   3
`define MMSC_MODE_LSB     2
`define MMSC_BUS_BSY      7
`define MMSC_BUS_CLKLOW   4
`define MMSC_BUS_CMD      1
`define MMSC_BUS_REL      0
`define MMSC_ST_DONE      0
`define MMSC_ST_BUSY      1
`define MMSC_ST_START     2
`define MMSC_ST_STOP      3
`define MMSC_ST_MATCH     6
`define MMSC_MODE_RST     8'h00
`define MMSC_BUS_RST      8'h00
`define MMSC_SVA_RST      8'h00
`define MMSC_BITS         4'h8
`define MMSC_CLK_NS       100
`define MMSC_SCK_HALF_NS  400
`define MMSC_SCK_HALF_CYC ((`MMSC_SCK_HALF_NS) / (`MMSC_CLK_NS))
`endif

// file: rtl/mmsc_dev.sv
// Serial channel device end with APB register slave
`include "mmsc_defines.svh"
module mmsc_dev import mmsc_pkg::*; (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    // APB slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Transfer end flag level
    output logic             transfer_interrupt,
    // Serial link
    mmsc_if.dev              lnk
);
    logic [2:0]  sck_s, a_s, b_s;
    logic [7:0]  mode_reg, mode_next, bus_reg, bus_next, sva_reg, sva_next;
    logic [7:0]  sr_reg, sr_next, sr_sh;
    logic        done_reg, done_next, start_reg, start_next, stop_reg, stop_next;
    logic        match_reg, match_next, active_reg, active_next, addr_reg, addr_next;
    logic [3:0]  cnt_reg, cnt_next;
    logic [3:0]  div_reg, div_next;
    logic        sck_drv_reg, sck_drv_next, out_reg, out_next;
    logic [31:0] prdata_reg, prdata_next;
    logic        pready_reg, pready_next, slverr_reg, slverr_next;
    logic [5:0]  pin_reg, pin_next;
    mmsc_mode_e  mode;
    logic        en, wake, lsb, rx_bit, sda, sck_rise, sck_fall, wr, setup, shifting;

    function automatic logic mmsc_mapped(input logic [7:0] a);
        return a == `MMSC_OFF_DATA || a == `MMSC_OFF_MODE || a == `MMSC_OFF_BUSCTL ||
               a == `MMSC_OFF_STATUS || a == `MMSC_OFF_SVA;
    endfunction

    // Pin synchronisers; stage 0 feeds only stage 1
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sck_s <= 3'h7;
            a_s   <= 3'h7;
            b_s   <= 3'h7;
        end else if (ce) begin
            sck_s <= {sck_s[1:0], lnk.sck};
            a_s   <= {a_s[1:0], lnk.line_a};
            b_s   <= {b_s[1:0], lnk.line_b};
        end
    end

    assign mode     = mmsc_mode_e'(mode_reg[1:0]); // see R01
    assign en       = mode_reg[`MMSC_MODE_EN];
    assign wake     = mode_reg[`MMSC_MODE_WAKE] && mode == MMSC_I2C;
    assign lsb      = mode_reg[`MMSC_MODE_LSB] && mode == MMSC_3W; // see R05
    assign sda      = mode_reg[`MMSC_MODE_LINEB] ? b_s[1] : a_s[1]; // see R06
    assign rx_bit   = (mode == MMSC_3W) ? a_s[1] : sda; // see R12
    assign sck_rise = sck_s[1] && !sck_s[2];
    assign sck_fall = !sck_s[1] && sck_s[2];
    assign setup    = psel && !penable;
    assign wr       = psel && penable && pready_reg && pwrite;
    assign sr_sh    = lsb ? {rx_bit, sr_reg[7:1]} : {sr_reg[6:0], rx_bit};

    always_comb begin
        mode_next    = mode_reg;
        bus_next     = bus_reg;
        sva_next     = sva_reg;
        sr_next      = sr_reg;
        done_next    = done_reg;
        start_next   = start_reg;
        stop_next    = stop_reg;
        match_next   = match_reg;
        active_next  = active_reg;
        addr_next    = addr_reg;
        cnt_next     = cnt_reg;
        div_next     = div_reg;
        sck_drv_next = sck_drv_reg;
        out_next     = out_reg;
        prdata_next  = prdata_reg;
        pready_next  = setup;
        slverr_next  = setup && !mmsc_mapped(paddr);
        shifting     = active_reg || addr_reg;
        // Read data is fetched in setup so it leaves a flip-flop
        if (setup) begin
            case (paddr)
                `MMSC_OFF_DATA:   prdata_next = {24'h0, sr_reg};
                `MMSC_OFF_MODE:   prdata_next = {24'h0, mode_reg};
                `MMSC_OFF_BUSCTL: prdata_next = {24'h0, bus_reg};
                `MMSC_OFF_STATUS: prdata_next = {25'h0, match_reg, 2'h0, stop_reg, start_reg,
                                                 active_reg, done_reg};
                `MMSC_OFF_SVA:    prdata_next = {24'h0, sva_reg};
                default:          prdata_next = 32'h0;
            endcase
        end
        if (wr) begin
            case (paddr)
                `MMSC_OFF_DATA: begin
                    // Writes in stopped, disabled or wakeup state are dropped
                    if (en && mode != MMSC_STOP && !wake) begin // see R11, R16, R03
                        sr_next     = pwdata[7:0]; // see R10
                        cnt_next    = 4'h0; // see R20
                        active_next = 1'b1;
                        div_next    = 4'h0;
                        out_next    = (mode == MMSC_3W && mode_reg[`MMSC_MODE_LSB]) ? pwdata[0] : pwdata[7];
                    end
                end
                `MMSC_OFF_MODE: begin
                    // Mode fields move only while disabled or in a write that clears enable
                    if (en && pwdata[`MMSC_MODE_EN]) // see R02
                        mode_next = mode_reg;
                    else
                        mode_next = pwdata[7:0];
                    if (!pwdata[`MMSC_MODE_EN]) begin
                        active_next = 1'b0;
                        addr_next   = 1'b0;
                        match_next  = 1'b0;
                    end
                end
                `MMSC_OFF_BUSCTL: begin
                    // Latch set/clear strobes are not stored
                    bus_next = {pwdata[7:2], 2'h0};
                    if (pwdata[`MMSC_BUS_CMD])
                        out_next = 1'b0; // see R07
                    if (pwdata[`MMSC_BUS_REL])
                        out_next = 1'b1; // see R07
                end
                `MMSC_OFF_STATUS: begin
                    if (pwdata[`MMSC_ST_DONE])
                        done_next = 1'b0;
                    if (pwdata[`MMSC_ST_START])
                        start_next = 1'b0;
                    if (pwdata[`MMSC_ST_STOP])
                        stop_next = 1'b0;
                end
                `MMSC_OFF_SVA: sva_next = pwdata[7:0];
                default: ;
            endcase
        end
        // Events below come after clears so a set is never lost
        if (en && mode != MMSC_STOP) begin // see R03
            if (mode == MMSC_I2C && sck_s[1] && sck_s[2]) begin
                if (!sda && (mode_reg[`MMSC_MODE_LINEB] ? b_s[2] : a_s[2])) begin
                    start_next = 1'b1; // see R09
                    if (wake) begin
                        addr_next = 1'b1;
                        cnt_next  = 4'h0;
                    end
                end
                if (sda && !(mode_reg[`MMSC_MODE_LINEB] ? b_s[2] : a_s[2])) begin
                    stop_next = 1'b1; // see R09
                    addr_next = 1'b0;
                    if (wake)
                        done_next = 1'b1; // see R19
                end
            end
            if (shifting && sck_fall && cnt_reg != 4'h0)
                out_next = lsb ? sr_reg[0] : sr_reg[7]; // see R18, R12
            if (shifting && sck_rise) begin
                sr_next  = sr_sh; // see R04, R18
                cnt_next = cnt_reg + 4'h1;
                if (cnt_reg == `MMSC_BITS - 4'h1) begin
                    active_next = 1'b0;
                    addr_next   = 1'b0;
                    if (addr_reg) begin
                        match_next = (sr_sh == sva_reg);
                        if (sr_sh == sva_reg)
                            done_next = 1'b1; // see R19
                    end else if (!wake) begin
                        done_next = 1'b1; // see R17
                    end
                end
            end
            // Own clock runs only for a started transfer
            if (active_reg && !wake) begin
                if (div_reg == 4'(`MMSC_SCK_HALF_CYC - 1)) begin
                    div_next     = 4'h0;
                    sck_drv_next = !sck_drv_reg;
                end else begin
                    div_next = div_reg + 4'h1;
                end
            end else begin
                div_next     = 4'h0;
                sck_drv_next = !bus_reg[`MMSC_BUS_CLKLOW]; // see R07
            end
        end else begin
            active_next  = 1'b0;
            addr_next    = 1'b0;
            sck_drv_next = 1'b1;
            div_next     = 4'h0;
        end
        // Pins: {sck_o, sck_oe, a_o, a_oe, b_o, b_oe}
        case (en ? mode : MMSC_STOP)
            MMSC_3W: pin_next = {sck_drv_next, 1'b1, 1'b1, 1'b0, out_next, 1'b1}; // see R04
            MMSC_2W, MMSC_I2C: begin
                pin_next = {1'b0, !sck_drv_next, 4'h0};
                if (mode_reg[`MMSC_MODE_LINEB])
                    pin_next[1:0] = {1'b0, !out_next}; // see R06, R08
                else
                    pin_next[3:2] = {1'b0, !out_next};
            end
            default: pin_next = 6'h0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_reg    <= `MMSC_MODE_RST;
            bus_reg     <= `MMSC_BUS_RST;
            sva_reg     <= `MMSC_SVA_RST;
            done_reg    <= 1'b0;
            start_reg   <= 1'b0;
            stop_reg    <= 1'b0;
            match_reg   <= 1'b0;
            active_reg  <= 1'b0;
            addr_reg    <= 1'b0;
            cnt_reg     <= 4'h0;
            div_reg     <= 4'h0;
            sck_drv_reg <= 1'b1;
            out_reg     <= 1'b1;
            prdata_reg  <= 32'h0;
            pready_reg  <= 1'b0;
            slverr_reg  <= 1'b0;
            pin_reg     <= 6'h0;
        end else if (ce) begin
            mode_reg    <= mode_next;
            bus_reg     <= bus_next;
            sva_reg     <= sva_next;
            done_reg    <= done_next;
            start_reg   <= start_next;
            stop_reg    <= stop_next;
            match_reg   <= match_next;
            active_reg  <= active_next;
            addr_reg    <= addr_next;
            cnt_reg     <= cnt_next;
            div_reg     <= div_next;
            sck_drv_reg <= sck_drv_next;
            out_reg     <= out_next;
            prdata_reg  <= prdata_next;
            pready_reg  <= pready_next;
            slverr_reg  <= slverr_next;
            pin_reg     <= pin_next;
        end
    end

    // Shift register has no reset by design
    always_ff @(posedge clk) begin
        if (ce)
            sr_reg <= sr_next; // see R15
    end

    assign prdata             = prdata_reg;
    assign pready             = pready_reg;
    assign pslverr            = slverr_reg;
    assign transfer_interrupt = done_reg;
    assign lnk.dev_sck_o      = pin_reg[5];
    assign lnk.dev_sck_oe     = pin_reg[4];
    assign lnk.dev_a_o        = pin_reg[3];
    assign lnk.dev_a_oe       = pin_reg[2];
    assign lnk.dev_b_o        = pin_reg[1];
    assign lnk.dev_b_oe       = pin_reg[0];
endmodule // mmsc_dev

// file: rtl/mmsc_if.sv
// Serial link between the channel and its partner
interface mmsc_if;
    logic dev_sck_o, dev_sck_oe, dev_a_o, dev_a_oe, dev_b_o, dev_b_oe;
    logic peer_sck_o, peer_sck_oe, peer_a_o, peer_a_oe, peer_b_o, peer_b_oe;
    logic sck, line_a, line_b;

    // Any driven low wins; undriven lines are pulled up
    function automatic logic mmsc_wire(input logic o1, e1, o2, e2);
        return !((e1 && !o1) || (e2 && !o2));
    endfunction

    assign sck    = mmsc_wire(dev_sck_o, dev_sck_oe, peer_sck_o, peer_sck_oe);
    assign line_a = mmsc_wire(dev_a_o, dev_a_oe, peer_a_o, peer_a_oe);
    assign line_b = mmsc_wire(dev_b_o, dev_b_oe, peer_b_o, peer_b_oe);

    modport dev  (output dev_sck_o, dev_sck_oe, dev_a_o, dev_a_oe, dev_b_o, dev_b_oe,
                  input sck, line_a, line_b);
    modport peer (output peer_sck_o, peer_sck_oe, peer_a_o, peer_a_oe, peer_b_o, peer_b_oe,
                  input sck, line_a, line_b);
endinterface

// file: rtl/mmsc_peer.sv
// Serial partner end: slave or clock master
`include "mmsc_defines.svh"
module mmsc_peer import mmsc_pkg::*; (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       ce,
    // Configuration
    input  wire mmsc_mode_e cfg_mode,
    input  wire logic       cfg_lsb,
    input  wire logic       cfg_line_b,
    input  wire logic       cfg_master,
    // User transfer port
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_start,
    input  wire logic       tx_start_cond,
    input  wire logic       tx_stop_cond,
    output logic            busy,
    output logic [7:0]      rx_data,
    output logic            rx_valid,
    // Serial link
    mmsc_if.peer            lnk
);
    logic [2:0]   sck_s, a_s, b_s;
    mmsc_pstate_e st_reg, st_next;
    logic [7:0]   sr_reg, sr_next, sr_sh;
    logic [3:0]   cnt_reg, cnt_next, div_reg, div_next;
    logic         out_reg, out_next, sck_reg, sck_next, stop_reg, stop_next;
    logic         valid_reg, valid_next, step_reg, step_next;
    logic [5:0]   pin_reg, pin_next;
    logic         rx_bit, rise, fall, tick;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sck_s <= 3'h7;
            a_s   <= 3'h7;
            b_s   <= 3'h7;
        end else if (ce) begin
            sck_s <= {sck_s[1:0], lnk.sck};
            a_s   <= {a_s[1:0], lnk.line_a};
            b_s   <= {b_s[1:0], lnk.line_b};
        end
    end

    assign rx_bit = (cfg_mode == MMSC_3W) ? b_s[1] : (cfg_line_b ? b_s[1] : a_s[1]);
    assign rise   = sck_s[1] && !sck_s[2];
    assign fall   = !sck_s[1] && sck_s[2];
    assign tick   = div_reg == 4'(`MMSC_SCK_HALF_CYC - 1);
    assign sr_sh  = (cfg_lsb && cfg_mode == MMSC_3W) ? {rx_bit, sr_reg[7:1]} : {sr_reg[6:0], rx_bit};

    always_comb begin
        st_next    = st_reg;
        sr_next    = sr_reg;
        cnt_next   = cnt_reg;
        out_next   = out_reg;
        sck_next   = sck_reg;
        stop_next  = stop_reg;
        step_next  = step_reg;
        valid_next = 1'b0;
        div_next   = tick ? 4'h0 : div_reg + 4'h1;
        case (st_reg)
            MMSC_P_IDLE: begin
                div_next = 4'h0;
                sck_next = 1'b1;
                if (tx_start) begin
                    sr_next   = tx_data;
                    cnt_next  = 4'h0; // see R20
                    stop_next = tx_stop_cond && cfg_master && cfg_mode == MMSC_I2C;
                    out_next  = (cfg_lsb && cfg_mode == MMSC_3W) ? tx_data[0] : tx_data[7];
                    st_next   = (tx_start_cond && cfg_master && cfg_mode == MMSC_I2C) ? MMSC_P_START
                                                                                      : MMSC_P_BITS;
                    if (tx_start_cond && cfg_master && cfg_mode == MMSC_I2C)
                        out_next = 1'b0; // see R08
                end
            end
            MMSC_P_START: begin
                // Clock drops before the first bit so no false stop
                if (tick) begin
                    step_next = !step_reg;
                    if (!step_reg) begin
                        sck_next = 1'b0;
                    end else begin
                        out_next = sr_reg[7];
                        st_next  = MMSC_P_BITS;
                    end
                end
            end
            MMSC_P_BITS: begin
                if (cfg_master && tick)
                    sck_next = !sck_reg;
                if (fall && cnt_reg != 4'h0)
                    out_next = (cfg_lsb && cfg_mode == MMSC_3W) ? sr_reg[0] : sr_reg[7];
                if (rise) begin
                    sr_next  = sr_sh;
                    cnt_next = cnt_reg + 4'h1;
                    if (cnt_reg == `MMSC_BITS - 4'h1) begin // see R17
                        valid_next = 1'b1;
                        sck_next   = 1'b1;
                        step_next  = 1'b0;
                        div_next   = 4'h0;
                        st_next    = stop_reg ? MMSC_P_STOP : MMSC_P_IDLE;
                    end
                end
            end
            MMSC_P_STOP: begin
                // Clock and data low together, then clock high, then data high
                if (tick) begin
                    step_next = !step_reg;
                    if (!step_reg && sck_reg) begin
                        sck_next  = 1'b0;
                        out_next  = 1'b0;
                        step_next = 1'b0;
                    end else if (!sck_reg) begin
                        sck_next = 1'b1;
                    end else begin
                        out_next = 1'b1; // see R08
                        st_next  = MMSC_P_IDLE;
                    end
                end
            end
            default: st_next = MMSC_P_IDLE;
        endcase
        // Pins: {sck_o, sck_oe, a_o, a_oe, b_o, b_oe}
        case (cfg_mode)
            MMSC_3W: pin_next = {sck_next, cfg_master, out_next, 1'b1, 2'h0};
            MMSC_2W, MMSC_I2C: begin
                pin_next = {1'b0, cfg_master && !sck_next, 4'h0};
                if (cfg_line_b)
                    pin_next[1:0] = {1'b0, !out_next}; // see R13
                else
                    pin_next[3:2] = {1'b0, !out_next};
            end
            default: pin_next = 6'h0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg    <= MMSC_P_IDLE;
            sr_reg    <= 8'hff;
            cnt_reg   <= 4'h0;
            div_reg   <= 4'h0;
            out_reg   <= 1'b1;
            sck_reg   <= 1'b1;
            stop_reg  <= 1'b0;
            step_reg  <= 1'b0;
            valid_reg <= 1'b0;
            pin_reg   <= 6'h0;
        end else if (ce) begin
            st_reg    <= st_next;
            sr_reg    <= sr_next;
            cnt_reg   <= cnt_next;
            div_reg   <= div_next;
            out_reg   <= out_next;
            sck_reg   <= sck_next;
            stop_reg  <= stop_next;
            step_reg  <= step_next;
            valid_reg <= valid_next;
            pin_reg   <= pin_next;
        end
    end

    assign busy            = st_reg != MMSC_P_IDLE;
    assign rx_data         = sr_reg;
    assign rx_valid        = valid_reg;
    assign lnk.peer_sck_o  = pin_reg[5];
    assign lnk.peer_sck_oe = pin_reg[4];
    assign lnk.peer_a_o    = pin_reg[3];
    assign lnk.peer_a_oe   = pin_reg[2];
    assign lnk.peer_b_o    = pin_reg[1];
    assign lnk.peer_b_oe   = pin_reg[0];
endmodule // mmsc_peer

// file: rtl/mmsc_pkg.sv
// Types shared by both ends of the serial channel
package mmsc_pkg;
    typedef enum logic [1:0] {MMSC_STOP, MMSC_3W, MMSC_2W, MMSC_I2C} mmsc_mode_e;
    typedef enum logic [1:0] {MMSC_P_IDLE, MMSC_P_START, MMSC_P_BITS, MMSC_P_STOP} mmsc_pstate_e;
endpackage
